// ### logic/cbd_defs.vh
`ifndef CBD_DEFS_VH
`define CBD_DEFS_VH
// opcodes
`define OP_CMP_DIR   8'hb5
`define OP_CMP_IMM   8'hb4
`define OP_CMP_REG   5'h17
`define OP_CLR_ACC   8'he4
`define OP_CLR_CY    8'hc3
`define OP_CLR_BIT   8'hc2
`define OP_CPL_ACC   8'hf4
`define OP_CPL_CY    8'hb3
`define OP_CPL_BIT   8'hb2
`define OP_DEC_ADJ   8'hd4
`define OP_DEC_ACC   8'h14
`define OP_DEC_DIR   8'h15
`define OP_DEC_IND   7'h0b
`define OP_DEC_REG   5'h03
`define OP_DIVIDE    8'h84
// divide timing
`define DIV_CYCLES   3'h4
// reset values
`define ACC_RST      8'h00
`define B_RST        8'h00
`define PC_RST       16'h0000
// bcd correction
`define BCD_SIX      4'h6
`define BCD_NINE     4'h9
`endif

// ### logic/bcd_adjust.v
`timescale 1ns/10ps
`default_nettype none
`include "cbd_defs.vh"
module bcd_adjust (
  input  wire [7:0] acc_i,
  input  wire       carry_i,
  input  wire       aux_carry_flag_i,
  output wire [7:0] result_o,
  output wire       carry_o
);
  wire       lo_fix;
  wire [8:0] step1;
  wire       c1;
  wire       hi_fix;
  wire [4:0] hi_sum;
  assign lo_fix = (acc_i[3:0] > `BCD_NINE) | aux_carry_flag_i; // RQ11
  assign step1  = {1'b0, acc_i} + {5'h00, lo_fix ? `BCD_SIX : 4'h0};
  assign c1     = carry_i | step1[8]; // RQ13
  assign hi_fix = c1 | (step1[7:4] > `BCD_NINE); // RQ12
  assign hi_sum = {1'b0, step1[7:4]} + {1'b0, hi_fix ? `BCD_SIX : 4'h0};
  // net add is 00h, 06h, 60h or 66h
  assign result_o = {hi_sum[3:0], step1[3:0]}; // RQ14
  assign carry_o  = c1 | hi_sum[4]; // RQ13
endmodule
`default_nettype wire

// ### logic/div_unit.v
`timescale 1ns/10ps
`default_nettype none
`include "cbd_defs.vh"
module div_unit (
  input  wire       clk_i,
  input  wire       rstn_i,
  input  wire       start_i,
  input  wire [7:0] dividend_i,
  input  wire [7:0] divisor_i,
  output reg        done_o,
  output reg  [7:0] quot_o,
  output reg  [7:0] rem_o,
  output reg        zero_o
);
  // restoring divide, two quotient bits per cycle, four cycles
  reg  [2:0] cnt;
  reg  [7:0] q;
  reg  [7:0] r;
  reg  [7:0] d;
  reg        busy;
  wire [8:0] t1;
  wire [7:0] r1;
  wire       b1;
  wire [8:0] t2;
  wire [7:0] r2;
  wire       b2;
  wire [7:0] q_src;
  wire [7:0] r_src;
  wire [7:0] d_src;
  // first step runs on the start cycle straight from the operands
  assign q_src = busy ? q : dividend_i;
  assign r_src = busy ? r : 8'h00;
  assign d_src = busy ? d : divisor_i;
  assign t1 = {r_src, q_src[7]} - {1'b0, d_src};
  assign b1 = ~t1[8];
  assign r1 = b1 ? t1[7:0] : {r_src[6:0], q_src[7]};
  assign t2 = {r1, q_src[6]} - {1'b0, d_src};
  assign b2 = ~t2[8];
  assign r2 = b2 ? t2[7:0] : {r1[6:0], q_src[6]};
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt    <= 3'h0;
      q      <= 8'h00;
      r      <= 8'h00;
      d      <= 8'h00;
      busy   <= 1'b0;
      done_o <= 1'b0;
      quot_o <= 8'h00;
      rem_o  <= 8'h00;
      zero_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (start_i && !busy) begin
        busy   <= 1'b1;
        cnt    <= `DIV_CYCLES - 3'h1;
        q      <= {q_src[5:0], b1, b2};
        r      <= r2;
        d      <= divisor_i;
        zero_o <= (divisor_i == 8'h00); // RQ19
      end else if (busy) begin
        q   <= {q_src[5:0], b1, b2};
        r   <= r2;
        cnt <= cnt - 3'h1;
        if (cnt == 3'h1) begin
          busy   <= 1'b0;
          done_o <= 1'b1;
          quot_o <= {q_src[5:0], b1, b2};
          rem_o  <= r2;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ### logic/cbd_exec.v
// Functional notes
// RQ1 - compare acc with direct byte: opcode b5, three bytes, two cycles
// RQ2 - compare acc with immediate: opcode b4, three bytes, two cycles
// RQ3 - compare register with immediate: 10111rrr, three bytes, two cycles
// RQ4 - compare sets carry if first below second, operands unchanged
// RQ5 - unequal compare adds signed offset to already advanced pc
// RQ6 - clear accumulator to zero, no flag change, one byte one cycle
// RQ7 - clear carry or addressable bit, bit form two bytes one cycle
// RQ8 - complement accumulator, opcode f4, one cycle, no flags
// RQ9 - complement carry (b3) or addressed bit (b2), one cycle
// RQ10 - read-modify-write on a port uses the output latch value
// RQ11 - add six to low nibble if above nine or aux carry set
// RQ12 - then add six to high nibble if carry set or above nine
// RQ13 - decimal adjust sets carry on carry out, never clears it
// RQ14 - decimal adjust adds 00h, 06h, 60h or 66h; overflow kept
// RQ15 - decimal adjust opcode is d4
// RQ16 - decrement subtracts one, wraps zero to ffh, no flags
// RQ17 - decrement modes: acc, register, direct, register-indirect
// RQ18 - divide a by b unsigned, quotient a, remainder b, four cycles; the code takes five, done on the fifth
// RQ19 - divide by zero sets overflow
// RQ20 - divide always clears carry
// RQ21 - divide by zero leaves a and b unchanged
`timescale 1ns/10ps
`default_nettype none
`include "cbd_defs.vh"
module cbd_exec (
  input  wire        clk_i,
  input  wire        rstn_i,
  // instruction, presented with all bytes at once
  input  wire        issue_i,
  input  wire [7:0]  opcode_i,
  input  wire [7:0]  byte2_i,
  input  wire [7:0]  byte3_i,
  input  wire [15:0] pc_next_i,
  // operand fetched by the core: reg/direct/indirect byte or bit
  input  wire [7:0]  mem_rd_i,
  input  wire        bit_rd_i,
  input  wire        acc_i,
  input  wire [7:0]  acc_val_i,
  input  wire [7:0]  b_val_i,
  input  wire        carry_i,
  input  wire        aux_carry_flag_i,
  input  wire        overflow_flag_i,
  // outputs
  output reg         busy_o,
  output reg         done_o,
  output reg         illegal_o,
  output reg  [7:0]  acc_o,
  output reg         acc_we_o,
  output reg  [7:0]  b_o,
  output reg         b_we_o,
  output reg         carry_o,
  output reg         overflow_flag_o,
  output reg         flags_we_o,
  output reg  [7:0]  mem_wr_o,
  output reg         mem_we_o,
  output reg  [7:0]  mem_addr_o,
  output reg         mem_ind_o,
  output reg         bit_o,
  output reg         bit_we_o,
  output reg  [15:0] pc_o,
  output reg         pc_we_o
);
  // ------------------------------------------------------------
  // state machine
  // ------------------------------------------------------------
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_CMP2 = 2'h1;
  localparam [1:0] ST_DIV  = 2'h2;
  reg  [1:0]  state;
  reg  [1:0]  next_state;
  reg  [15:0] cmp_target;
  reg         cmp_taken;
  reg         cmp_carry;
  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  wire is_cmp_dir = (opcode_i == `OP_CMP_DIR); // RQ1
  wire is_cmp_imm = (opcode_i == `OP_CMP_IMM); // RQ2
  wire is_cmp_reg = (opcode_i[7:3] == `OP_CMP_REG); // RQ3
  wire is_clr_acc = (opcode_i == `OP_CLR_ACC);
  wire is_clr_cy  = (opcode_i == `OP_CLR_CY);
  wire is_clr_bit = (opcode_i == `OP_CLR_BIT);
  wire is_cpl_acc = (opcode_i == `OP_CPL_ACC);
  wire is_cpl_cy  = (opcode_i == `OP_CPL_CY);
  wire is_cpl_bit = (opcode_i == `OP_CPL_BIT);
  wire is_da      = (opcode_i == `OP_DEC_ADJ); // RQ15
  wire is_dec_acc = (opcode_i == `OP_DEC_ACC);
  wire is_dec_dir = (opcode_i == `OP_DEC_DIR);
  wire is_dec_ind = (opcode_i[7:1] == `OP_DEC_IND);
  wire is_dec_reg = (opcode_i[7:3] == `OP_DEC_REG);
  wire is_div     = (opcode_i == `OP_DIVIDE);
  // ------------------------------------------------------------
  // compare datapath
  // ------------------------------------------------------------
  // first operand: acc for acc forms, register for the register form
  wire [7:0]  cmp_a   = is_cmp_reg ? mem_rd_i : acc_val_i;
  // second operand: direct byte or the immediate constant
  wire [7:0]  cmp_b   = is_cmp_dir ? mem_rd_i : byte2_i;
  wire        cmp_lt  = (cmp_a < cmp_b); // RQ4
  wire        cmp_ne  = (cmp_a != cmp_b);
  // signed offset added to pc already past the instruction
  wire [15:0] cmp_dst = pc_next_i + {{8{byte3_i[7]}}, byte3_i}; // RQ5
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  wire [7:0] da_res;
  wire       da_cy;
  wire       div_done;
  wire [7:0] div_q;
  wire [7:0] div_r;
  wire       div_zero;
  wire [7:0] dec_src = is_dec_acc ? acc_val_i : mem_rd_i;
  // mem_rd_i must be latch content for ports, never pin levels
  wire [7:0] dec_res = dec_src - 8'h01; // RQ16 RQ10
  bcd_adjust u_bcd (
    .acc_i            (acc_val_i),
    .carry_i          (carry_i),
    .aux_carry_flag_i (aux_carry_flag_i),
    .result_o         (da_res),
    .carry_o          (da_cy)
  );
  div_unit u_div (
    .clk_i      (clk_i),
    .rstn_i     (rstn_i),
    .start_i    (issue_i && state == ST_IDLE && is_div),
    .dividend_i (acc_val_i),
    .divisor_i  (b_val_i),
    .done_o     (div_done),
    .quot_o     (div_q),
    .rem_o      (div_r),
    .zero_o     (div_zero)
  );
  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (issue_i && (is_cmp_dir || is_cmp_imm || is_cmp_reg))
          next_state = ST_CMP2;
        else if (issue_i && is_div)
          next_state = ST_DIV;
      end
      ST_CMP2: next_state = ST_IDLE;
      ST_DIV: begin
        if (div_done)
          next_state = ST_IDLE;
      end
      default: next_state = ST_IDLE;
    endcase
  end
  // ------------------------------------------------------------
  // execute
  // ------------------------------------------------------------
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state           <= ST_IDLE;
      cmp_target      <= `PC_RST;
      cmp_taken       <= 1'b0;
      cmp_carry       <= 1'b0;
      busy_o          <= 1'b0;
      done_o          <= 1'b0;
      illegal_o       <= 1'b0;
      acc_o           <= `ACC_RST;
      acc_we_o        <= 1'b0;
      b_o             <= `B_RST;
      b_we_o          <= 1'b0;
      carry_o         <= 1'b0;
      overflow_flag_o <= 1'b0;
      flags_we_o      <= 1'b0;
      mem_wr_o        <= 8'h00;
      mem_we_o        <= 1'b0;
      mem_addr_o      <= 8'h00;
      mem_ind_o       <= 1'b0;
      bit_o           <= 1'b0;
      bit_we_o        <= 1'b0;
      pc_o            <= `PC_RST;
      pc_we_o         <= 1'b0;
    end else begin
      state      <= next_state;
      done_o     <= 1'b0;
      illegal_o  <= 1'b0;
      acc_we_o   <= 1'b0;
      b_we_o     <= 1'b0;
      flags_we_o <= 1'b0;
      mem_we_o   <= 1'b0;
      bit_we_o   <= 1'b0;
      pc_we_o    <= 1'b0;
      carry_o         <= carry_i;
      overflow_flag_o <= overflow_flag_i;
      case (state)
        ST_IDLE: begin
          if (issue_i) begin
            busy_o <= 1'b0;
            done_o <= 1'b1;
            if (is_cmp_dir || is_cmp_imm || is_cmp_reg) begin
              // first cycle: resolve; second cycle: commit
              busy_o     <= 1'b1; // RQ1 RQ2 RQ3
              done_o     <= 1'b0;
              cmp_target <= cmp_dst;
              cmp_taken  <= cmp_ne;
              cmp_carry  <= cmp_lt; // RQ4
              carry_o    <= cmp_lt; // RQ4
            end else if (is_clr_acc) begin
              acc_o    <= 8'h00; // RQ6
              acc_we_o <= 1'b1;
            end else if (is_cpl_acc) begin
              acc_o    <= ~acc_val_i; // RQ8
              acc_we_o <= 1'b1;
            end else if (is_clr_cy) begin
              carry_o    <= 1'b0; // RQ7
              flags_we_o <= 1'b1;
            end else if (is_cpl_cy) begin
              carry_o    <= ~carry_i; // RQ9
              flags_we_o <= 1'b1;
            end else if (is_clr_bit || is_cpl_bit) begin
              mem_addr_o <= byte2_i;
              bit_o      <= is_cpl_bit & ~bit_rd_i; // RQ7 RQ9 RQ10
              bit_we_o   <= 1'b1;
            end else if (is_da) begin
              acc_o      <= da_res; // RQ14
              acc_we_o   <= 1'b1;
              carry_o    <= da_cy; // RQ13
              flags_we_o <= 1'b1;
            end else if (is_dec_acc) begin
              acc_o    <= dec_res; // RQ17
              acc_we_o <= 1'b1;
            end else if (is_dec_reg || is_dec_dir || is_dec_ind) begin
              mem_addr_o <= is_dec_dir ? byte2_i :
                            {5'h00, opcode_i[2:0]}; // RQ17
              mem_ind_o  <= is_dec_ind;
              mem_wr_o   <= dec_res; // RQ16
              mem_we_o   <= 1'b1;
            end else if (is_div) begin
              busy_o <= 1'b1;
              done_o <= 1'b0;
            end else begin
              illegal_o <= 1'b1;
            end
          end
        end
        ST_CMP2: begin
          busy_o     <= 1'b0;
          done_o     <= 1'b1;
          flags_we_o <= 1'b1;
          carry_o    <= cmp_carry; // RQ4
          pc_o       <= cmp_target; // RQ5
          pc_we_o    <= cmp_taken;
        end
        ST_DIV: begin
          if (div_done) begin
            busy_o          <= 1'b0;
            done_o          <= 1'b1;
            carry_o         <= 1'b0; // RQ20
            overflow_flag_o <= div_zero; // RQ18 RQ19
            flags_we_o      <= 1'b1;
            // zero divisor: a and b stay as they were
            acc_o    <= div_q; // RQ18
            b_o      <= div_r;
            acc_we_o <= ~div_zero; // RQ21
            b_we_o   <= ~div_zero; // RQ21
          end
        end
        default: busy_o <= 1'b0;
      endcase
    end
  end
endmodule
`default_nettype wire

// ### tb/cbd_chk.sv
`timescale 1ns/10ps
`default_nettype none
module cbd_chk (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic issue_i,
  input wire logic [7:0] opcode_i,
  input wire logic [7:0] byte2_i,
  input wire logic [7:0] byte3_i,
  input wire logic [15:0] pc_next_i,
  input wire logic [7:0] mem_rd_i,
  input wire logic bit_rd_i,
  input wire logic [7:0] acc_val_i,
  input wire logic [7:0] b_val_i,
  input wire logic carry_i,
  input wire logic aux_carry_flag_i,
  input wire logic overflow_flag_i,
  input wire logic busy_o,
  input wire logic done_o,
  input wire logic [7:0] acc_o,
  input wire logic acc_we_o,
  input wire logic [7:0] b_o,
  input wire logic b_we_o,
  input wire logic carry_o,
  input wire logic overflow_flag_o,
  input wire logic flags_we_o,
  input wire logic [7:0] mem_wr_o,
  input wire logic mem_we_o,
  input wire logic bit_o,
  input wire logic bit_we_o,
  input wire logic [15:0] pc_o,
  input wire logic pc_we_o
);
  logic go;
  logic lt;
  logic [8:0] lo, hi, da;
  logic [7:0] q, r, dv;
  logic [15:0] tgt;
  assign go = issue_i && !busy_o;
  assign lo = {1'h0, acc_val_i} + ((acc_val_i[3:0] > 4'h9 ||
    aux_carry_flag_i) ? 9'h006 : 9'h000);
  assign hi = lo + ((carry_i || lo[8] || lo[7:4] > 4'h9) ? 9'h060 : 9'h000);
  assign da = {carry_i | hi[8], hi[7:0]};
  assign q = acc_val_i / b_val_i;
  assign r = acc_val_i % b_val_i;
  assign dv = mem_rd_i - 8'h01;
  assign lt = acc_val_i < (opcode_i[0] ? mem_rd_i : byte2_i);
  assign tgt = pc_next_i + {{8{byte3_i[7]}}, byte3_i};
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  a_clr_acc: assert property (
    go && opcode_i == 8'he4 |=> acc_we_o && acc_o == 8'h00 && !flags_we_o)
    else $error("clear acc wrong");
  a_cpl_acc: assert property (
    go && opcode_i == 8'hf4 |=> acc_o == ~$past(acc_val_i) && !flags_we_o)
    else $error("complement acc wrong");
  a_cpl_bit: assert property (
    go && opcode_i == 8'hb2 |=> bit_we_o && bit_o == !$past(bit_rd_i))
    else $error("complement bit wrong");
  a_dec_reg: assert property (
    go && opcode_i[7:3] == 5'h03 |=> mem_we_o && mem_wr_o == $past(dv))
    else $error("decrement wrong");
  a_bcd_adj: assert property (
    go && opcode_i == 8'hd4 |=> {carry_o, acc_o} == $past(da) &&
    overflow_flag_o == $past(overflow_flag_i)) else $error("adjust wrong");
  a_cmp_carry: assert property (
    go && opcode_i[7:1] == 7'h5a |=> busy_o ##1 done_o && flags_we_o &&
    carry_o == $past(lt, 2)) else $error("compare carry wrong");
  a_cmp_jump: assert property (
    go && opcode_i[7:3] == 5'h17 && mem_rd_i != byte2_i |-> ##2
    pc_we_o && pc_o == $past(tgt, 2)) else $error("branch wrong");
  a_div_ok: assert property (
    go && opcode_i == 8'h84 && b_val_i != 8'h00 |=> busy_o [*4] ##1
    done_o && !carry_o && !overflow_flag_o && acc_o == $past(q, 5) &&
    b_o == $past(r, 5)) else $error("divide wrong");
  a_div_zero: assert property (
    go && opcode_i == 8'h84 && b_val_i == 8'h00 |-> ##5 done_o &&
    overflow_flag_o && !carry_o && !acc_we_o && !b_we_o)
    else $error("divide by zero wrong");
  c_div_zero: cover property (go && opcode_i == 8'h84 && b_val_i == 8'h00);
  c_jump: cover property (pc_we_o);
  c_da_carry: cover property (go && opcode_i == 8'hd4 && da[8] && !carry_i);
endmodule
bind cbd_exec cbd_chk i_chk (.clk_i, .rstn_i, .issue_i, .opcode_i, .byte2_i,
  .byte3_i, .pc_next_i, .mem_rd_i, .bit_rd_i, .acc_val_i, .b_val_i, .carry_i,
  .aux_carry_flag_i, .overflow_flag_i, .busy_o, .done_o, .acc_o, .acc_we_o,
  .b_o, .b_we_o, .carry_o, .overflow_flag_o, .flags_we_o, .mem_wr_o,
  .mem_we_o, .bit_o, .bit_we_o, .pc_o, .pc_we_o);
`default_nettype wire

// ### tb/compare_clear_bcd_div_exec_tb.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin n_fail++; \
  $display("wrong value t=%0t got %h exp %h", $time, a, e); end end
module compare_clear_bcd_div_exec_tb;
  logic clk_i = 1'h0, rstn_i = 1'h0, issue_i = 1'h0, acc_i = 1'h0;
  logic bit_rd_i = 1'h0, carry_i = 1'h0, aux_carry_flag_i = 1'h0;
  logic overflow_flag_i = 1'h0;
  logic [7:0] opcode_i = 8'h00, byte2_i = 8'h00, byte3_i = 8'h00;
  logic [7:0] mem_rd_i = 8'h00, acc_val_i = 8'h00, b_val_i = 8'h00;
  logic [15:0] pc_next_i = 16'h1000;
  logic busy_o, done_o, illegal_o, acc_we_o, b_we_o, carry_o, flags_we_o;
  logic overflow_flag_o, mem_we_o, mem_ind_o, bit_o, bit_we_o, pc_we_o;
  logic [7:0] acc_o, b_o, mem_wr_o, mem_addr_o, op, b2, b3, a, b, m, x, y;
  logic [15:0] pc_o;
  int n_fail = 0, total_checks = 0, lat;
  localparam logic [23:0] da_tab [5] = '{24'hbe2241, 24'hc92291,
    24'h56ab61, 24'h126180, 24'h342340};
  localparam logic [31:0] dec_tab [4] = '{32'h140000ff, 32'h1b00100f,
    32'h153000ff, 32'h17007f7e};
  localparam logic [39:0] cmp_tab [4] = '{40'hb500103434, 40'hb420fe1000,
    40'hbf60050056, 40'hb87f800080};
  localparam logic [15:0] div_tab [4] = '{16'hfb12, 16'h0708, 16'h5500,
    16'hff01};

  cbd_exec i_dut (.clk_i, .rstn_i, .issue_i, .opcode_i, .byte2_i, .byte3_i,
    .pc_next_i, .mem_rd_i, .bit_rd_i, .acc_i, .acc_val_i, .b_val_i, .carry_i,
    .aux_carry_flag_i, .overflow_flag_i, .busy_o, .done_o, .illegal_o, .acc_o,
    .acc_we_o, .b_o, .b_we_o, .carry_o, .overflow_flag_o, .flags_we_o,
    .mem_wr_o, .mem_we_o, .mem_addr_o, .mem_ind_o, .bit_o, .bit_we_o, .pc_o,
    .pc_we_o);

  always #5 clk_i = ~clk_i;

  task print_verdict();
    $display("checks %0d, mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // issue one instruction, then wait for done and count cycles
  task go(input logic [7:0] o, c2, c3, av, bv, mv, input logic [3:0] f);
    @(posedge clk_i);
    issue_i <= 1'h1;
    opcode_i <= o;
    byte2_i <= c2;
    byte3_i <= c3;
    acc_val_i <= av;
    b_val_i <= bv;
    mem_rd_i <= mv;
    {carry_i, aux_carry_flag_i, overflow_flag_i, bit_rd_i} <= f;
    @(posedge clk_i);
    issue_i <= 1'h0;
    lat = 1;
    #1;
    while (done_o !== 1'h1 && lat < 8) begin
      @(posedge clk_i);
      #1;
      lat++;
    end
    if (done_o !== 1'h1) begin
      n_fail++;
      print_verdict();
    end
  endtask

  task t_bits();
    go(8'he4, 8'h00, 8'h00, 8'h5c, 8'h00, 8'h00, 4'h8);
    `CHK({acc_o, acc_we_o, flags_we_o, lat[1:0]}, 12'h009)
    go(8'hf4, 8'h00, 8'h00, 8'h5c, 8'h00, 8'h00, 4'h0);
    `CHK({acc_o, acc_we_o, flags_we_o}, 10'h28e)
    go(8'hc3, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 4'h8);
    `CHK({carry_o, flags_we_o}, 2'h1)
    go(8'hb3, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 4'h0);
    `CHK({carry_o, flags_we_o}, 2'h3)
    go(8'hc2, 8'h92, 8'h00, 8'h00, 8'h00, 8'h00, 4'h1);
    `CHK({bit_o, bit_we_o, mem_addr_o, flags_we_o}, 11'h324)
    go(8'hb2, 8'h91, 8'h00, 8'h00, 8'h00, 8'h00, 4'h1);
    `CHK({bit_o, bit_we_o, mem_addr_o}, 10'h191)
  endtask

  task t_da();
    for (int i = 0; i < 5; i++) begin
      go(8'hd4, 8'h00, 8'h00, da_tab[i][23:16], 8'h00, 8'h00,
        da_tab[i][15:12]);
      `CHK(acc_o, da_tab[i][11:4])
      `CHK({carry_o, overflow_flag_o}, {da_tab[i][0], 1'h1})
      `CHK({acc_we_o, lat[1:0]}, 3'h5)
    end
  endtask

  task t_dec();
    for (int i = 0; i < 4; i++) begin
      {op, b2, m} = dec_tab[i][31:8];
      go(op, b2, 8'h00, m, 8'h00, m, 4'h0);
      `CHK(flags_we_o, 1'h0)
      if (i == 0) `CHK({acc_o, acc_we_o}, 9'h1ff)
      else `CHK({mem_wr_o, mem_we_o, mem_ind_o}, {dec_tab[i][7:0], 1'h1, i == 3})
      if (i == 2) `CHK(mem_addr_o, 8'h30)
    end
  endtask

  task t_cmp();
    for (int i = 0; i < 4; i++) begin
      {op, b2, b3, a, m} = cmp_tab[i];
      x = op[3] ? m : a;
      y = (op == 8'hb5) ? m : b2;
      go(op, b2, b3, a, 8'h00, m, 4'h8);
      `CHK({carry_o, flags_we_o, pc_we_o}, {x < y, 1'h1, x != y})
      if (x != y) `CHK(pc_o, pc_next_i + {{8{b3[7]}}, b3})
      `CHK({acc_we_o, mem_we_o, lat[2:0]}, 5'h02)
    end
  endtask

  task t_div();
    for (int i = 0; i < 4; i++) begin
      {a, b} = div_tab[i];
      go(8'h84, 8'h00, 8'h00, a, b, 8'h00, 4'ha);
      `CHK({carry_o, overflow_flag_o, lat[2:0]}, {1'h0, b == 8'h00, 3'h5})
      if (b != 8'h00) `CHK({acc_o, b_o, acc_we_o, b_we_o}, {a / b, a % b, 2'h3})
      else `CHK({acc_we_o, b_we_o}, 2'h0)
    end
  endtask

  initial begin
    repeat (6) @(posedge clk_i);
    `CHK({busy_o, done_o, acc_we_o, pc_we_o}, 4'h0)
    rstn_i <= 1'h1;
    t_bits();
    t_da();
    t_dec();
    t_cmp();
    t_div();
    print_verdict();
  end
endmodule
`default_nettype wire
